/* File: verilog/emcsr_defs.svh */
/*
  constants of the energy manager configuration and status register bank:
  byte offsets, field positions and reset values.
  assumes it is included by bare name from the design modules.
*/
`ifndef EMCSR_DEFS_SVH
`define EMCSR_DEFS_SVH

// register byte offsets
`define EMCSR_A_ENERGY_MSB 8'h01
`define EMCSR_A_ENERGY_B2 8'h02
`define EMCSR_A_ENERGY_B3 8'h03
`define EMCSR_A_ENERGY_LSB 8'h04
`define EMCSR_A_STORE_V 8'h05
`define EMCSR_A_CHG_TARGET 8'h06
`define EMCSR_A_PROF_UPPER 8'h07
`define EMCSR_A_MODE_PROF_LO 8'h08
`define EMCSR_A_CHG_OUT_CFG 8'h0A
`define EMCSR_A_EW_CFG 8'h0B
`define EMCSR_A_MARGIN_CFG 8'h0D

// field positions
`define EMCSR_F_EW_THR 3:0
`define EMCSR_F_EW_EN 4
`define EMCSR_F_HIZ 4
`define EMCSR_F_PROF_UPPER 1:0
`define EMCSR_F_PROF_LO 7:4
`define EMCSR_F_MARGIN 1:0

// reset values
`define EMCSR_R_EW_THR 4'h0
`define EMCSR_R_EW_EN 1'b0
`define EMCSR_R_HIZ 1'b0
`define EMCSR_R_PROF_UPPER 2'h0
`define EMCSR_R_PROF_LO 4'h0
`define EMCSR_R_MARGIN 2'h3
`define EMCSR_R_BYTE 8'h00
`define EMCSR_R_FIXED 1'b1

// fixed mode profile number
`define EMCSR_PROF_FIXED 6'h00

`endif

/* File: verilog/emcsr_pkg.sv */
/*
  types of the energy manager register bank: device states and the
  structs that carry host accesses and configuration outputs.
  assumes emcsr_defs.svh is on the include path.
*/
package emcsr_pkg;
  // power state of the surrounding device
  typedef enum logic [1:0] {
    emcsr_idle_hold_state,
    emcsr_charge_state,
    emcsr_active_state
  } emcsr_dev_state_t;

  // one byte access from the serial configuration port
  typedef struct packed {
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
    logic [7:0] addr; // register byte offset
    logic [7:0] wdata; // write byte
  } emcsr_host_req_t;

  // settings handed to the analog and optimizer logic
  typedef struct packed {
    logic [3:0] ew_threshold; // early warning threshold code
    logic ew_enable; // early warning comparator on
    logic pulse_output_hiz; // pulse output pin high impedance
    logic [5:0] profile; // optimizer profile number
    logic fixed_mode; // profile zero, no learning
    logic fixed_eoc_applies; // fixed end-of-charge governs
    logic [1:0] opt_margin; // optimizer margin code
  } emcsr_cfg_t;
endpackage

/* File: verilog/emcsr_energy_acc.sv */
/*
  32-bit consumed-energy accumulator behind the fuel gauge result.
  assumes increments arrive as one-cycle pulses from the metering logic
  and charge_start is a one-cycle pulse at the start of each charge.
*/
`timescale 1ns/1ps
`include "emcsr_defs.svh"
module emcsr_energy_acc #(
  parameter int ACC_W = 32,
  parameter int INC_W = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic charge_start,
  input wire logic inc_valid,
  input wire logic [INC_W-1:0] inc_amount,
  output logic [ACC_W-1:0] energy_q
);
  typedef struct packed {
    logic [ACC_W-1:0] energy; // running result
  } emcsr_acc_st_t;

  emcsr_acc_st_t st_q; // registered state
  emcsr_acc_st_t st_d; // next state

  // clear wins the start of a charge; an increment in that cycle opens the
  // new count so no measured energy is dropped
  always_comb begin
    st_d = st_q;
    if (charge_start) begin
      st_d.energy = inc_valid ? ACC_W'(inc_amount) : '0;
    end else if (inc_valid) begin
      st_d.energy = st_q.energy + ACC_W'(inc_amount); // wraps, as a counter
    end
  end

  // sync reset, result reads zero until first measurement
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign energy_q = st_q.energy;
endmodule

/* File: verilog/emcsr_vstatus.sv */
/*
  storage-voltage and charge-target status codes.
  assumes the comparator ladder delivers 5-bit monotonic codes and the
  device state comes from the charger state machine.
*/
`timescale 1ns/1ps
`include "emcsr_defs.svh"
module emcsr_vstatus #(
  parameter int CODE_W = 5
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire emcsr_pkg::emcsr_dev_state_t dev_state,
  input wire logic charge_start,
  input wire logic [CODE_W-1:0] store_v_code,
  input wire logic [CODE_W-1:0] chg_target_code,
  output logic [CODE_W-1:0] store_v_q,
  output logic [CODE_W-1:0] chg_target_q
);
  typedef struct packed {
    logic [CODE_W-1:0] store_v; // measured storage voltage code
    logic [CODE_W-1:0] chg_target; // end-of-charge code in use
  } emcsr_vs_st_t;

  emcsr_vs_st_t st_q; // registered state
  emcsr_vs_st_t st_d; // next state

  // track only while charging or active; leakage in idle hold is not shown
  always_comb begin
    st_d = st_q;
    if (dev_state != emcsr_pkg::emcsr_idle_hold_state) begin
      st_d.store_v = store_v_code;
    end
    if (charge_start) begin
      st_d.chg_target = chg_target_code;
    end
  end

  // sync reset to code zero, the lowest voltage
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign store_v_q = st_q.store_v;
  assign chg_target_q = st_q.chg_target;
endmodule

/* File: verilog/emcsr_regs.sv */
/*
  energy manager configuration and status register bank, top level.
  holds the writable settings, decodes host byte accesses and returns
  read data one cycle after a read strobe.
  assumes the serial port front end delivers one-cycle byte strobes
  synchronous to core_clk, and the charger supplies state and codes.
*/
`timescale 1ns/1ps
`include "emcsr_defs.svh"
module emcsr_regs #(
  parameter int INC_W = 16,
  parameter int CODE_W = 5
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire emcsr_pkg::emcsr_host_req_t host_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire emcsr_pkg::emcsr_dev_state_t dev_state,
  input wire logic energy_inc_valid,
  input wire logic [INC_W-1:0] energy_inc,
  input wire logic [CODE_W-1:0] store_v_code,
  input wire logic [CODE_W-1:0] chg_target_code,
  output emcsr_pkg::emcsr_cfg_t cfg
);
  // whole state of the bank outside the u_acc and u_vs submodules
  typedef struct packed {
    logic [3:0] ew_thr; // early warning threshold code
    logic ew_en; // early warning enable
    logic hiz_sel; // pulse output high impedance select
    logic [1:0] prof_upper; // profile bits 5:4
    logic [3:0] prof_lo; // profile bits 3:0
    logic [1:0] margin; // optimizer margin code
    logic hiz_out; // hiz gated by state
    logic fixed; // profile is zero
    logic [7:0] rdata; // read answer
    logic rvalid; // read answer strobe
    emcsr_pkg::emcsr_dev_state_t prev_state; // for charge start edge
  } emcsr_top_st_t;

  emcsr_top_st_t st_q; // registered state
  emcsr_top_st_t st_d; // next state
  logic charge_start; // first cycle of charge state
  logic [31:0] energy; // fuel gauge result
  logic [CODE_W-1:0] store_v; // storage voltage status
  logic [CODE_W-1:0] chg_target; // charge target status

  // byte select of the 32-bit result, msb first
  function automatic logic [7:0] energy_byte(input logic [31:0] e, input logic [1:0] idx);
    energy_byte = e[31 - 8*idx -: 8];
  endfunction

  // a charge cycle starts on entry into the charge state
  assign charge_start = (dev_state == emcsr_pkg::emcsr_charge_state) &&
                        (st_q.prev_state != emcsr_pkg::emcsr_charge_state);

  // fuel gauge accumulator
  emcsr_energy_acc #(
    .ACC_W(32),
    .INC_W(INC_W)
  ) u_acc (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .charge_start(charge_start),
    .inc_valid(energy_inc_valid),
    .inc_amount(energy_inc),
    .energy_q(energy)
  );

  // voltage status codes
  emcsr_vstatus #(
    .CODE_W(CODE_W)
  ) u_vs (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .dev_state(dev_state),
    .charge_start(charge_start),
    .store_v_code(store_v_code),
    .chg_target_code(chg_target_code),
    .store_v_q(store_v),
    .chg_target_q(chg_target)
  );

  // writes, reads and derived outputs
  always_comb begin
    st_d = st_q;
    st_d.prev_state = dev_state;
    st_d.rvalid = host_req.rd;
    // write decode; unmapped offsets are ignored
    if (host_req.wr) begin
      unique case (host_req.addr)
        `EMCSR_A_EW_CFG: begin
          st_d.ew_thr = host_req.wdata[`EMCSR_F_EW_THR];
          st_d.ew_en = host_req.wdata[`EMCSR_F_EW_EN];
        end
        `EMCSR_A_CHG_OUT_CFG: begin
          st_d.hiz_sel = host_req.wdata[`EMCSR_F_HIZ];
        end
        `EMCSR_A_PROF_UPPER: begin
          st_d.prof_upper = host_req.wdata[`EMCSR_F_PROF_UPPER];
        end
        `EMCSR_A_MODE_PROF_LO: begin
          st_d.prof_lo = host_req.wdata[`EMCSR_F_PROF_LO];
        end
        `EMCSR_A_MARGIN_CFG: begin
          st_d.margin = host_req.wdata[`EMCSR_F_MARGIN];
        end
        default: begin
          st_d.ew_thr = st_q.ew_thr; // no writable register behind this offset
        end
      endcase
    end
    // read decode; write-only and unmapped offsets answer zero
    st_d.rdata = st_q.rdata;
    if (host_req.rd) begin
      unique case (host_req.addr)
        `EMCSR_A_ENERGY_MSB: st_d.rdata = energy_byte(energy, 2'h0);
        `EMCSR_A_ENERGY_B2: st_d.rdata = energy_byte(energy, 2'h1);
        `EMCSR_A_ENERGY_B3: st_d.rdata = energy_byte(energy, 2'h2);
        `EMCSR_A_ENERGY_LSB: st_d.rdata = energy_byte(energy, 2'h3);
        `EMCSR_A_STORE_V: st_d.rdata = 8'(store_v);
        `EMCSR_A_CHG_TARGET: st_d.rdata = 8'(chg_target);
        default: st_d.rdata = `EMCSR_R_BYTE;
      endcase
    end
    // high impedance only in idle hold and active; charge keeps it driven
    st_d.hiz_out = st_d.hiz_sel &&
                   (dev_state != emcsr_pkg::emcsr_charge_state);
    // zero profile means fixed mode and the fixed end-of-charge setting
    st_d.fixed = ({st_d.prof_upper, st_d.prof_lo} == `EMCSR_PROF_FIXED);
  end

  // sync reset to documented defaults
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q.ew_thr <= `EMCSR_R_EW_THR;
      st_q.ew_en <= `EMCSR_R_EW_EN;
      st_q.hiz_sel <= `EMCSR_R_HIZ;
      st_q.prof_upper <= `EMCSR_R_PROF_UPPER;
      st_q.prof_lo <= `EMCSR_R_PROF_LO;
      st_q.margin <= `EMCSR_R_MARGIN;
      st_q.hiz_out <= `EMCSR_R_HIZ;
      st_q.fixed <= `EMCSR_R_FIXED;
      st_q.rdata <= `EMCSR_R_BYTE;
      st_q.rvalid <= 1'b0;
      st_q.prev_state <= emcsr_pkg::emcsr_idle_hold_state;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign rd_data = st_q.rdata;
  assign rd_valid = st_q.rvalid;
  assign cfg.ew_threshold = st_q.ew_thr;
  assign cfg.ew_enable = st_q.ew_en;
  assign cfg.pulse_output_hiz = st_q.hiz_out;
  assign cfg.profile = {st_q.prof_upper, st_q.prof_lo};
  assign cfg.fixed_mode = st_q.fixed;
  assign cfg.fixed_eoc_applies = st_q.fixed;
  assign cfg.opt_margin = st_q.margin;

  // checks
  property p_ew_write;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.wr && host_req.addr == `EMCSR_A_EW_CFG |=>
        cfg.ew_threshold == $past(host_req.wdata[`EMCSR_F_EW_THR]);
  endproperty
  a_ew_write: assert property (p_ew_write) else $error("threshold not taken");

  property p_ew_enable;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.wr && host_req.addr == `EMCSR_A_EW_CFG |=>
        cfg.ew_enable == $past(host_req.wdata[`EMCSR_F_EW_EN]);
  endproperty
  a_ew_enable: assert property (p_ew_enable) else $error("enable not taken");

  property p_hiz;
    @(posedge core_clk) disable iff (!reset_n)
      cfg.pulse_output_hiz |-> $past(dev_state) != emcsr_pkg::emcsr_charge_state;
  endproperty
  a_hiz: assert property (p_hiz) else $error("hiz during charge");

  property p_prof_low;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.wr && host_req.addr == `EMCSR_A_MODE_PROF_LO |=>
        cfg.profile[3:0] == $past(host_req.wdata[`EMCSR_F_PROF_LO]);
  endproperty
  a_prof_low: assert property (p_prof_low) else $error("profile low wrong");

  property p_fixed;
    @(posedge core_clk) disable iff (!reset_n)
      cfg.fixed_mode == (cfg.profile == `EMCSR_PROF_FIXED) && cfg.fixed_eoc_applies == cfg.fixed_mode;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed mode mismatch");

  property p_margin;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.wr && host_req.addr == `EMCSR_A_MARGIN_CFG |=>
        cfg.opt_margin == $past(host_req.wdata[`EMCSR_F_MARGIN]);
  endproperty
  a_margin: assert property (p_margin) else $error("margin not taken");

  property p_rd_lsb;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.rd && host_req.addr == `EMCSR_A_ENERGY_LSB |=>
        rd_valid && rd_data == $past(energy[7:0]);
  endproperty
  a_rd_lsb: assert property (p_rd_lsb) else $error("energy lsb wrong");

  property p_clear;
    @(posedge core_clk) disable iff (!reset_n)
      charge_start && !energy_inc_valid |=> energy == 32'h00000000;
  endproperty
  a_clear: assert property (p_clear) else $error("energy not cleared");

  property p_hold;
    @(posedge core_clk) disable iff (!reset_n)
      dev_state == emcsr_pkg::emcsr_idle_hold_state |=> $stable(store_v);
  endproperty
  a_hold: assert property (p_hold) else $error("status moved in idle");

  property p_target;
    @(posedge core_clk) disable iff (!reset_n)
      charge_start |=> chg_target == $past(chg_target_code);
  endproperty
  a_target: assert property (p_target) else $error("target not loaded");

  // both upper profile bits land together
  property p_prof_upper;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.wr && host_req.addr == `EMCSR_A_PROF_UPPER |=>
        cfg.profile[5:4] == $past(host_req.wdata[`EMCSR_F_PROF_UPPER]);
  endproperty
  a_prof_upper: assert property (p_prof_upper) else $error("profile upper wrong");

  // most significant energy byte sits at the lowest offset
  property p_rd_msb;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.rd && host_req.addr == `EMCSR_A_ENERGY_MSB |=>
        rd_valid && rd_data == $past(energy[31:24]);
  endproperty
  a_rd_msb: assert property (p_rd_msb) else $error("energy msb wrong");

  // one answer strobe per read strobe, never a spare one
  property p_rd_valid;
    @(posedge core_clk) disable iff (!reset_n)
      rd_valid == $past(host_req.rd);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read strobe mismatch");

  // a write to the energy msb byte must not disturb threshold, profile or margin
  property p_ro_write;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.wr && host_req.addr == `EMCSR_A_ENERGY_MSB |=>
        $stable(cfg.ew_threshold) && $stable(cfg.profile) && $stable(cfg.opt_margin);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

  // outside charge the pulse output follows the stored select bit
  property p_hiz_follow;
    @(posedge core_clk) disable iff (!reset_n)
      dev_state != emcsr_pkg::emcsr_charge_state |=> cfg.pulse_output_hiz == st_q.hiz_sel;
  endproperty
  a_hiz_follow: assert property (p_hiz_follow) else $error("hiz select ignored");

  // charging or active: status tracks the ladder one cycle late
  property p_track;
    @(posedge core_clk) disable iff (!reset_n)
      dev_state != emcsr_pkg::emcsr_idle_hold_state |=> store_v == $past(store_v_code);
  endproperty
  a_track: assert property (p_track) else $error("storage status not tracking");

  // storage code reads back with the upper bits zero
  property p_rd_store_v;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.rd && host_req.addr == `EMCSR_A_STORE_V |=>
        rd_data == 8'($past(store_v));
  endproperty
  a_rd_store_v: assert property (p_rd_store_v) else $error("storage read wrong");

  // target code reads back in the same code space
  property p_rd_target;
    @(posedge core_clk) disable iff (!reset_n)
      host_req.rd && host_req.addr == `EMCSR_A_CHG_TARGET |=>
        rd_data == 8'($past(chg_target));
  endproperty
  a_rd_target: assert property (p_rd_target) else $error("target read wrong");

  // target moves only at charge start, later ladder changes are ignored
  property p_target_hold;
    @(posedge core_clk) disable iff (!reset_n)
      !charge_start |=> $stable(chg_target);
  endproperty
  a_target_hold: assert property (p_target_hold) else $error("target moved");

  // main scenarios: charge entry, optimizer profile, hiz, reads, frozen status
  c_charge: cover property (@(posedge core_clk) disable iff (!reset_n) charge_start);
  c_opt: cover property (@(posedge core_clk) disable iff (!reset_n) !cfg.fixed_mode);
  c_hiz: cover property (@(posedge core_clk) disable iff (!reset_n) cfg.pulse_output_hiz);
  c_read: cover property (@(posedge core_clk) disable iff (!reset_n) rd_valid);
  c_freeze: cover property (@(posedge core_clk) disable iff (!reset_n)
    dev_state == emcsr_pkg::emcsr_idle_hold_state && store_v_code != store_v);
endmodule

/* File: bench/emcsr_host_model.sv */
/*
  host microcontroller model: byte writes and reads on the serial
  configuration port, one strobe cycle per byte.
  assumes the bench calls xfer from one process at a time.
*/
`timescale 1ns/1ps
module emcsr_host_model (
  input wire logic core_clk,
  output emcsr_pkg::emcsr_host_req_t host_req
);
  // idle port: no strobes
  initial host_req = '0;

  // one byte access, launched and released at falling edges
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    host_req.wr = w;
    host_req.rd = ~w;
    host_req.addr = a;
    host_req.wdata = d;
    @(negedge core_clk);
    host_req.wr = 1'b0;
    host_req.rd = 1'b0;
    // released lines must not keep the old value
    host_req.addr = ~a;
    host_req.wdata = ~d;
  endtask
endmodule

/* File: bench/emcsr_regs_tb_top.sv */
/*
  self-checking bench of the register bank: host traffic through the
  host model, charger stimulus, read results checked from a queue.
  assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
module emcsr_regs_tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  emcsr_pkg::emcsr_host_req_t host_req;
  logic [7:0] rd_data;
  logic rd_valid;
  emcsr_pkg::emcsr_dev_state_t dev_state = emcsr_pkg::emcsr_idle_hold_state;
  logic inc_v = 1'b0;
  logic [15:0] inc = 16'h0000;
  logic [4:0] sv_code = 5'h00;
  logic [4:0] ct_code = 5'h00;
  emcsr_pkg::emcsr_cfg_t cfg;
  logic [7:0] exp_q[$]; // expected read bytes, oldest first
  logic [31:0] seed = 32'hA4CE;
  logic [31:0] energy = 32'h0000_0000; // model of the accumulator
  int bad_count = 0;
  int checks = 0;

  emcsr_host_model host (.core_clk(core_clk), .host_req(host_req));

  emcsr_regs #(.INC_W(16), .CODE_W(5)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .host_req(host_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .dev_state(dev_state),
    .energy_inc_valid(inc_v), .energy_inc(inc), .store_v_code(sv_code),
    .chg_target_code(ct_code), .cfg(cfg));

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  // pseudo random source
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask

  // note the expectation before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask

  task automatic chk_cfg(input logic [3:0] t, input logic e, input logic h,
                         input logic [5:0] p, input logic [1:0] m);
    chk(cfg.ew_threshold, t);
    chk(cfg.ew_enable, e);
    chk(cfg.pulse_output_hiz, h);
    chk(cfg.profile, p);
    chk(cfg.fixed_mode, p == 6'h00);
    chk(cfg.fixed_eoc_applies, p == 6'h00);
    chk(cfg.opt_margin, m);
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // read answers: settled at the falling edge after the strobe
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(rd_data, 32'hFFFF_FFFF);
      end else begin
        chk(rd_data, exp_q.pop_front());
      end
    end
  end

  // whole run is about 135 cycles
  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end

  initial begin
    logic [31:0] r;
    logic [5:0] p;
    logic [3:0] t;
    logic h;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    chk_cfg(4'h0, 1'b0, 1'b0, 6'h00, 2'h3);
    // random settings, profile zero every third pass
    for (int i = 0; i < 8; i++) begin
      r = lfsr();
      p = (i % 3 == 0) ? 6'h00 : r[13:8];
      t = r[3:0] % 4'hA;
      h = r[16];
      wr(8'h0B, {r[7:5], r[4], t});
      wr(8'h0A, {3'h2, h, 4'h0});
      wr(8'h07, {r[29:24], p[5:4]});
      wr(8'h08, {p[3:0], 4'h0});
      wr(8'h0D, {r[31:26], r[25:24]});
      chk_cfg(t, r[4], h, p, r[25:24]);
    end
    // read-only and unmapped places take no writes
    wr(8'h01, 8'h5A);
    wr(8'h0E, 8'hFF);
    chk_cfg(t, r[4], h, p, r[25:24]);
    rd(8'h0B, 8'h00);
    rd(8'h0E, 8'h00);
    // metered energy, increments back to back
    inc_v = 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = lfsr();
      inc = r[15:0];
      energy = energy + r[15:0];
      @(negedge core_clk);
    end
    inc_v = 1'b0;
    for (int b = 0; b < 4; b++) rd(8'(b + 1), energy[31 - 8 * b -: 8]);
    // charge entry clears energy and loads the target
    sv_code = 5'h1F;
    ct_code = 5'h15;
    dev_state = emcsr_pkg::emcsr_charge_state;
    repeat (2) @(negedge core_clk);
    chk(cfg.pulse_output_hiz, 1'b0);
    for (int b = 0; b < 4; b++) rd(8'(b + 1), 8'h00);
    ct_code = 5'h03;
    rd(8'h06, 8'h15);
    rd(8'h05, 8'h1F);
    // idle hold freezes the storage voltage status
    dev_state = emcsr_pkg::emcsr_idle_hold_state;
    @(negedge core_clk);
    sv_code = 5'h00;
    rd(8'h05, 8'h1F);
    dev_state = emcsr_pkg::emcsr_active_state;
    repeat (2) @(negedge core_clk);
    chk(cfg.pulse_output_hiz, h);
    rd(8'h05, 8'h00);
    repeat (4) @(negedge core_clk);
    chk(exp_q.size(), 32'h0);
    wrap_up();
  end
endmodule
